// ### bench/rrs_exec_checker.sv
`timescale 1ns/1ps
module rrs_exec_checker
(
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic        instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic [14:0] stack_head,
   input wire logic [7:0]  file_rdata,
   input wire logic        busy,
   input wire logic [14:0] program_counter,
   input wire logic [7:0]  acc,
   input wire logic        arith_out_bit,
   input wire logic        half_byte_out_bit,
   input wire logic        result_nil_flag,
   input wire logic        expiry_flag,
   input wire logic        power_down_flag,
   input wire logic        global_irq_enable,
   input wire logic [7:0]  watchdog_counter,
   input wire logic [7:0]  watchdog_prescaler,
   input wire logic        sleep_req,
   input wire logic [6:0]  file_addr,
   input wire logic [7:0]  file_wdata,
   input wire logic        file_we
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   wire       tk = instr_valid && !busy;
   wire [5:0] op = instr_word[13:8];
   wire [7:0] k  = instr_word[7:0];
   a_ret_lit: assert property (tk && op == 6'h34 |=> acc == $past(k)
      && program_counter == $past(stack_head) && busy ##1 !busy)
      else $error("return literal wrong");
   a_ret_sub: assert property (tk && instr_word == 14'h0008 |=> busy
      && $stable(arith_out_bit) && $stable(result_nil_flag)
      && program_counter == $past(stack_head))
      else $error("subroutine return wrong");
   a_irq_ret: assert property (tk && instr_word == 14'h0009 |=> global_irq_enable
      && busy && program_counter == $past(stack_head))
      else $error("interrupt return wrong");
   a_rot_left: assert property (tk && op == 6'h0d |=> arith_out_bit == $past(file_rdata[7])
      && (file_we ? file_wdata : acc) == {$past(file_rdata[6:0]), $past(arith_out_bit)})
      else $error("rotate left wrong");
   a_rot_right: assert property (tk && op == 6'h0c |=> arith_out_bit == $past(file_rdata[0])
      && (file_we ? file_wdata : acc) == {$past(arith_out_bit), $past(file_rdata[7:1])})
      else $error("rotate right wrong");
   a_rot_dest: assert property (tk && op[5:1] == 5'h06 && instr_word[7] |=> file_we
      && file_addr == $past(instr_word[6:0]) && $stable(acc))
      else $error("rotate destination wrong");
   a_sleep_clr: assert property (tk && instr_word == 14'h0063 |=> watchdog_counter == 8'h00
      && watchdog_prescaler == 8'h00 && expiry_flag && !power_down_flag && sleep_req)
      else $error("sleep wrong");
   a_sub_acc: assert property (tk && op == 6'h3c |=> acc == 8'($past(k) - $past(acc))
      && result_nil_flag == (acc == 8'h00))
      else $error("subtract result wrong");
   a_sub_carry: assert property (tk && op == 6'h3c |=> arith_out_bit == ($past(acc) <= $past(k))
      && half_byte_out_bit == ($past(acc[3:0]) <= $past(k[3:0])))
      else $error("subtract carries wrong");
   c_ret: cover property (tk && op == 6'h34);
   c_sub: cover property (tk && op == 6'h3c);
   c_sleep: cover property (tk && instr_word == 14'h0063);
endmodule : rrs_exec_checker
bind rrs_exec rrs_exec_checker chk (.*);

// ### bench/rrs_exec_test.sv
`timescale 1ns/1ps
module rrs_exec_test;
   logic        sys_clk = 0, srst = 1, instr_valid = 0, ret_sel = 0, busy, pc_load, stack_pop;
   logic [13:0] instr_word = 14'h0000;
   logic [14:0] stack_head = 15'h0000, program_counter;
   logic [7:0]  file_rdata = 8'h00, acc, watchdog_counter, watchdog_prescaler, file_wdata;
   logic [6:0]  file_addr;
   logic        arith_out_bit, half_byte_out_bit, result_nil_flag, expiry_flag;
   logic        power_down_flag, global_irq_enable, sleep_req, file_we;
   int          fails = 0, total_checks = 0, cyc = 0;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; \
   $display("unexpected at %0t: %h vs %h", $time, a, b); end end
   rrs_exec dut (.*);
   initial forever #25 sys_clk = ~sys_clk;
   // Whole run needs about 41 cycles; ceiling at 3000 is generous
   always @(posedge sys_clk)
   begin
      cyc = cyc + 1;
      if (cyc == 3000)
      begin
         fails++;
         finish_test();
      end
   end
   task finish_test();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : finish_test
   task issue(input logic [13:0] w, input logic [7:0] fr, input logic [14:0] s);
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= w;
      file_rdata <= fr;
      stack_head <= s;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      // Stale operands inverted so a late sample cannot match
      file_rdata <= ~fr;
      stack_head <= ~s;
      #1;
   endtask : issue
   task t_ret();
      issue(14'h34ab, 8'h00, 15'h1234);
      `CHK({acc, program_counter, busy, pc_load, stack_pop}, {8'hab, 15'h1234, 3'b111})
      @(posedge sys_clk);
      #1;
      `CHK({busy, pc_load}, 2'b00)
      issue(14'h3cab, 8'h00, 15'h0000);
      issue(14'h0008, 8'h00, 15'h0321);
      `CHK({program_counter, arith_out_bit, half_byte_out_bit, result_nil_flag}, 18'h0190f)
      `CHK(global_irq_enable, 1'b0)
      issue(14'h0009, 8'h00, 15'h7fff);
      `CHK({program_counter, global_irq_enable}, {15'h7fff, 1'b1})
      $display("returns done");
   endtask : t_ret
   task t_sub(input logic [7:0] k, input logic [7:0] w);
      logic [7:0] r;
      r = k - w;
      issue({6'h34, w}, 8'h00, 15'h0000);
      issue({6'h3c, k}, 8'h00, 15'h0000);
      `CHK({acc, arith_out_bit, half_byte_out_bit, result_nil_flag},
         {r, w <= k, w[3:0] <= k[3:0], r == 8'h00})
      $display("subtract done");
   endtask : t_sub
   task t_rot();
      issue(14'h0d05, 8'he6, 15'h0000);
      `CHK({acc, arith_out_bit, file_we}, {8'hcc, 2'b10})
      issue(14'h0dff, 8'h80, 15'h0000);
      `CHK({acc, file_wdata, file_addr, arith_out_bit, file_we}, {16'hcc01, 7'h7f, 2'b11})
      issue(14'h0c10, 8'h02, 15'h0000);
      `CHK({acc, arith_out_bit, half_byte_out_bit, result_nil_flag}, {8'h81, 3'b000})
      issue(14'h0c80, 8'h01, 15'h0000);
      `CHK({file_wdata, file_addr, arith_out_bit, file_we}, {8'h00, 7'h00, 2'b11})
      $display("rotate done");
   endtask : t_rot
   task t_sleep();
      issue(14'h0063, 8'h00, 15'h0000);
      `CHK({watchdog_counter, watchdog_prescaler, expiry_flag, power_down_flag, sleep_req},
         {16'h0000, 3'b101})
      $display("sleep done");
   endtask : t_sleep
   task t_busy();
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= 14'h345a;
      @(posedge sys_clk);
      instr_word <= 14'h3c00;
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      #1;
      `CHK({acc, busy}, {8'h5a, 1'b0})
      $display("busy refusal done");
   endtask : t_busy
   initial
   begin
      repeat (3) @(posedge sys_clk);
      srst <= 1'b0;
      #1;
      `CHK({acc, expiry_flag, power_down_flag, global_irq_enable, program_counter}, 26'h0030000)
      t_ret();
      t_sub(8'h03, 8'h05);
      t_sub(8'h10, 8'h01);
      t_sub(8'hff, 8'h00);
      t_sub(8'h00, 8'hff);
      t_rot();
      t_sleep();
      t_busy();
      finish_test();
   end
endmodule : rrs_exec_test

// ### design/rrs_alu.sv
`timescale 1ns/1ps
`include "rrs_cfg.svh"
module rrs_alu
   import rrs_pkg::*;
(
   input  wire rrs_op_type op,
   input  wire logic [7:0] lit,
   input  wire logic [7:0] acc,
   input  wire logic [7:0] src,
   input  wire logic       carry_in,
   output logic [7:0]      result,
   output logic            carry_out,
   output logic            half_out,
   output logic            nil_out
);
   logic [8:0] diff;
   logic [4:0] hdiff;
   always_comb
   begin
      diff      = {1'b0, lit} - {1'b0, acc};
      hdiff     = {1'b0, lit[3:0]} - {1'b0, acc[3:0]};
      result    = src;
      carry_out = carry_in;
      half_out  = 1'b0;
      nil_out   = 1'b0;
      case (op)
         RRS_OP_ROTL:
         begin
            result    = {src[6:0], carry_in};
            carry_out = src[7];
         end
         RRS_OP_ROTR:
         begin
            result    = {carry_in, src[7:1]};
            carry_out = src[0];
         end
         RRS_OP_SUBLIT:
         begin
            result    = diff[7:0];
            carry_out = ~diff[8];
            half_out  = ~hdiff[4];
            nil_out   = (diff[7:0] == 8'h00);
         end
         default:
         begin
            result = src;
         end
      endcase
   end
endmodule : rrs_alu

// ### design/rrs_cfg.svh
`ifndef RRS_CFG_SVH
`define RRS_CFG_SVH
`define RRS_PC_W        15
`define RRS_ADDR_W      7
`define RRS_WDT_W       8
`define RRS_PRE_W       8
`define RRS_WDT_CLR     8'h00
`define RRS_PRE_CLR     8'h00
`define RRS_ACC_RST     8'h00
`define RRS_PC_RST      15'h0000
`define RRS_RET_CYCLES  2'h2
`define RRS_GIE_BIT     7
`define RRS_RLF_BIT     6
`define RRS_RRF_BIT     7
`endif

// ### design/rrs_exec.sv
`timescale 1ns/1ps
`include "rrs_cfg.svh"
// What this block does
// - Return-with-literal loads accumulator with literal, program counter from stack head; two cycles.
// - Subroutine return pops stack, loads program counter, two cycles, flags untouched.
// - Rotate left: bit n to n+1, bit 7 to carry, carry to bit 0.
// - Rotate right: bit n to n-1, bit 0 to carry, carry to bit 7.
// - Rotate destination 0 writes accumulator, 1 writes register; address 0 to 127.
// - Sleep clears watchdog and prescaler, sets expiry flag, clears power-down flag.
// - Subtract: literal minus accumulator into accumulator, updates three flags.
// - Subtract carry is 0 if accumulator above literal, else 1.
// - Subtract half carry is 0 if accumulator low nibble above literal's, else 1.
// - Interrupt return pops stack, sets global enable bit 7, two cycles.
module rrs_exec
   import rrs_pkg::*;
(
   input  wire logic                   sys_clk,
   input  wire logic                   srst,
   input  wire logic                   instr_valid,
   input  wire logic [13:0]            instr_word,
   input  wire logic                   ret_sel,
   input  wire logic [`RRS_PC_W-1:0]   stack_head,
   input  wire logic [7:0]             file_rdata,
   output logic                        busy,
   output logic [`RRS_PC_W-1:0]        program_counter,
   output logic                        pc_load,
   output logic                        stack_pop,
   output logic [7:0]                  acc,
   output logic                        arith_out_bit,
   output logic                        half_byte_out_bit,
   output logic                        result_nil_flag,
   output logic                        expiry_flag,
   output logic                        power_down_flag,
   output logic                        global_irq_enable,
   output logic [`RRS_WDT_W-1:0]       watchdog_counter,
   output logic [`RRS_PRE_W-1:0]       watchdog_prescaler,
   output logic                        sleep_req,
   output logic [`RRS_ADDR_W-1:0]      file_addr,
   output logic [7:0]                  file_wdata,
   output logic                        file_we
);
   // Word 0009h is taken as the interrupt return, so the low bit of the
   // subroutine return never reaches this decoder as a shadow restore
   // Select input is spare for now; kept so the fetch side need not change
   // Unknown words decode to no operation and leave all state alone
   function automatic rrs_op_type decode_op(input logic [13:0] w, input logic sel);
      rrs_op_type o;
      o = RRS_OP_NONE;
      if (w[13:8] == 6'h34)
      begin
         o = RRS_OP_RETLIT;
      end
      else if (w[13:8] == 6'h0d)
      begin
         o = RRS_OP_ROTL;
      end
      else if (w[13:8] == 6'h0c)
      begin
         o = RRS_OP_ROTR;
      end
      else if (w[13:8] == 6'h3c)
      begin
         o = RRS_OP_SUBLIT;
      end
      else if (w == 14'h0063)
      begin
         o = RRS_OP_SLEEP;
      end
      else if (w == 14'h0008)
      begin
         o = RRS_OP_RETSUB;
      end
      else if (w == 14'h0009)
      begin
         o = RRS_OP_RETIRQ;
      end
      return o;
   endfunction : decode_op

   rrs_op_type         op;
   rrs_state_type      state_r, state_nxt;
   logic [7:0]         alu_res;
   logic               alu_c, alu_dc, alu_z;
   logic [`RRS_PC_W-1:0] pc_nxt;
   logic [7:0]         acc_nxt, wdata_nxt;
   logic [`RRS_ADDR_W-1:0] addr_nxt;
   logic               c_nxt, dc_nxt, z_nxt, to_nxt, pd_nxt, gie_nxt;
   logic               busy_nxt, load_nxt, pop_nxt, we_nxt, sleep_nxt;
   logic [`RRS_WDT_W-1:0] wdt_nxt;
   logic [`RRS_PRE_W-1:0] pre_nxt;
   logic               go;

   assign go = instr_valid && (state_r == RRS_ST_IDLE);
   assign op = go ? decode_op(instr_word, ret_sel) : RRS_OP_NONE;

   rrs_alu u_alu (
      .op        (op),
      .lit       (instr_word[7:0]),
      .acc       (acc),
      .src       (file_rdata),
      .carry_in  (arith_out_bit),
      .result    (alu_res),
      .carry_out (alu_c),
      .half_out  (alu_dc),
      .nil_out   (alu_z)
   );

   always_comb
   begin
      state_nxt = RRS_ST_IDLE;
      pc_nxt    = program_counter;
      acc_nxt   = acc;
      c_nxt     = arith_out_bit;
      dc_nxt    = half_byte_out_bit;
      z_nxt     = result_nil_flag;
      to_nxt    = expiry_flag;
      pd_nxt    = power_down_flag;
      gie_nxt   = global_irq_enable;
      wdt_nxt   = watchdog_counter;
      pre_nxt   = watchdog_prescaler;
      busy_nxt  = 1'b0;
      load_nxt  = 1'b0;
      pop_nxt   = 1'b0;
      we_nxt    = 1'b0;
      sleep_nxt = 1'b0;
      addr_nxt  = file_addr;
      wdata_nxt = file_wdata;
      // Second cycle of a return only flushes; fetch must hold off meanwhile
      case (op)
         RRS_OP_RETLIT, RRS_OP_RETSUB, RRS_OP_RETIRQ:
         begin
            pc_nxt    = stack_head;
            pop_nxt   = 1'b1;
            load_nxt  = 1'b1;
            busy_nxt  = 1'b1;
            state_nxt = RRS_ST_RET2;
            if (op == RRS_OP_RETLIT)
               acc_nxt = instr_word[7:0];
            if (op == RRS_OP_RETIRQ)
               gie_nxt = 1'b1;
         end
         RRS_OP_ROTL, RRS_OP_ROTR:
         begin
            c_nxt = alu_c;
            if (instr_word[`RRS_ADDR_W] == 1'b0)
               acc_nxt = alu_res;
            else
            begin
               we_nxt    = 1'b1;
               addr_nxt  = instr_word[`RRS_ADDR_W-1:0];
               wdata_nxt = alu_res;
            end
         end
         RRS_OP_SLEEP:
         begin
            wdt_nxt   = `RRS_WDT_CLR;
            pre_nxt   = `RRS_PRE_CLR;
            to_nxt    = 1'b1;
            pd_nxt    = 1'b0;
            sleep_nxt = 1'b1;
         end
         RRS_OP_SUBLIT:
         begin
            acc_nxt = alu_res;
            c_nxt   = alu_c;
            dc_nxt  = alu_dc;
            z_nxt   = alu_z;
         end
         default:
         begin
            state_nxt = RRS_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_r            <= RRS_ST_IDLE;
         program_counter    <= `RRS_PC_RST;
         acc                <= `RRS_ACC_RST;
         arith_out_bit      <= 1'b0;
         half_byte_out_bit  <= 1'b0;
         result_nil_flag    <= 1'b0;
         // Power-on values of the status pair
         expiry_flag        <= 1'b1;
         power_down_flag    <= 1'b1;
         global_irq_enable  <= 1'b0;
         watchdog_counter   <= `RRS_WDT_CLR;
         watchdog_prescaler <= `RRS_PRE_CLR;
         busy               <= 1'b0;
         pc_load            <= 1'b0;
         stack_pop          <= 1'b0;
         sleep_req          <= 1'b0;
         file_we            <= 1'b0;
         file_addr          <= 7'h00;
         file_wdata         <= 8'h00;
      end
      else
      begin
         state_r            <= state_nxt;
         program_counter    <= pc_nxt;
         acc                <= acc_nxt;
         arith_out_bit      <= c_nxt;
         half_byte_out_bit  <= dc_nxt;
         result_nil_flag    <= z_nxt;
         expiry_flag        <= to_nxt;
         power_down_flag    <= pd_nxt;
         global_irq_enable  <= gie_nxt;
         watchdog_counter   <= wdt_nxt;
         watchdog_prescaler <= pre_nxt;
         busy               <= busy_nxt;
         pc_load            <= load_nxt;
         stack_pop          <= pop_nxt;
         sleep_req          <= sleep_nxt;
         file_we            <= we_nxt;
         file_addr          <= addr_nxt;
         file_wdata         <= wdata_nxt;
      end
   end
endmodule : rrs_exec

// ### design/rrs_pkg.sv
package rrs_pkg;
   typedef enum logic [2:0] {
      RRS_OP_NONE,
      RRS_OP_RETLIT,
      RRS_OP_RETSUB,
      RRS_OP_RETIRQ,
      RRS_OP_ROTL,
      RRS_OP_ROTR,
      RRS_OP_SLEEP,
      RRS_OP_SUBLIT
   } rrs_op_type;
   typedef enum logic {
      RRS_ST_IDLE,
      RRS_ST_RET2
   } rrs_state_type;
endpackage : rrs_pkg
